// File: pmon_regs.svh
// register map, field positions, reset values and timing counts of the power monitor
//------------------------------------------------------------------------------
// Contract
// - config register at 00h, read/write, reset value 4127h.
// - shunt-drop result at 01h, read-only, latest sense voltage, resets to zero.
// - rail-voltage result at 02h, read-only, latest bus voltage, resets to zero.
// - reading config changes nothing and leaves a running conversion alone.
// - config write stops any conversion; unless the mode is shutdown, a new one starts with new settings.
// - writing one to config bit 15 restores all defaults; bit self-clears.
// - bits 11:9 pick averaging of 1,4,16,64,128,256,512,1024 samples; default 1.
// - bits 8:6 pick rail conversion time 139..8205 us; default code 100.
// - bits 5:3 pick shunt conversion time, same steps; default code 100.
// - bits 2:0 mode: shutdown, triggered or continuous shunt/rail/both; default 111.
// - shunt-drop result is two's complement, bit 15 the sign.
// - shunt-drop count is 2.5 uV; 7FFF is positive full scale.
// - with averaging, shunt-drop result shows the averaged value.
// - rail result unsigned, bit 15 reads zero, 1.25 mV per count.
// - power result is always non-negative, unsigned over sixteen bits.
// - done flag clears on config write (not power-down) or alert select read.
// - power-on reset clears every register to default before any access.
//------------------------------------------------------------------------------
`ifndef PMON_REGS_SVH
`define PMON_REGS_SVH

//------------------------------------------------------------------------------
// command codes
//------------------------------------------------------------------------------
`define PM_ADDR_CFG     8'h00
`define PM_ADDR_SHUNT   8'h01
`define PM_ADDR_RAIL    8'h02
`define PM_ADDR_PWR     8'h03
`define PM_ADDR_CURR    8'h04
`define PM_ADDR_CAL     8'h05
`define PM_ADDR_ASEL    8'h06
`define PM_ADDR_LIM     8'h07
`define PM_ADDR_MAKER   8'hFE
`define PM_ADDR_PART    8'hFF

//------------------------------------------------------------------------------
// reset values and field positions
//------------------------------------------------------------------------------
`define PM_CFG_RESET    16'h4127
`define PM_ZERO16       16'h0000
`define PM_CFG_RST_BIT  15
`define PM_CFG_FIX_HI   14
`define PM_CFG_FIX_LO   12
`define PM_CFG_AVG_HI   11
`define PM_CFG_AVG_LO   9
`define PM_CFG_RCT_HI   8
`define PM_CFG_RCT_LO   6
`define PM_CFG_SCT_HI   5
`define PM_CFG_SCT_LO   3
`define PM_CFG_MODE_HI  2
`define PM_CFG_MODE_LO  0
`define PM_MODE_SHUNT   0
`define PM_MODE_RAIL    1
`define PM_MODE_CONT    2
`define PM_ASEL_WMASK   16'hFC03
`define PM_ASEL_CONV_DONE_FLAG    3
`define PM_ASEL_OVF     2

//------------------------------------------------------------------------------
// averaging counts and arithmetic scaling
//------------------------------------------------------------------------------
`define PM_AVG_N0       1
`define PM_AVG_N1       4
`define PM_AVG_N2       16
`define PM_AVG_N3       64
`define PM_AVG_N4       128
`define PM_AVG_N5       256
`define PM_AVG_N6       512
`define PM_AVG_N7       1024
`define PM_CURR_SHIFT   11
`define PM_PWR_SHIFT    14

//------------------------------------------------------------------------------
// conversion times
//------------------------------------------------------------------------------
`define PM_CLK_MHZ      40
`define PM_CT0_US       139
`define PM_CT1_US       203
`define PM_CT2_US       269
`define PM_CT3_US       525
`define PM_CT4_US       1037
`define PM_CT5_US       2061
`define PM_CT6_US       4109
`define PM_CT7_US       8205
`define PM_US2CYC(us)   ((us) * `PM_CLK_MHZ)

`endif

// File: pmon_pkg.sv
// types shared by the power monitor files
package pmon_pkg;

  typedef enum logic [1:0] {PM_IDLE, PM_SHUNT, PM_RAIL, PM_CALC} pmon_state_t;

endpackage

// File: pmon_avg_acc.sv
// sample accumulator that yields the average of a power-of-two sample count
`timescale 1ns/1ps
module pmon_avg_acc #(
  parameter int unsigned W     = 16,
  parameter bit          SGN   = 1'b1,
  parameter int unsigned ACC_W = 26
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clr,
  input  wire logic             add,
  input  wire logic [W-1:0]     sample,
  input  wire logic [3:0]       shift,
  output logic      [W-1:0]     avg
);

  //----------------------------------------------------------------------------
  // elaboration check
  //----------------------------------------------------------------------------
  // sum of 1024 samples needs ten guard bits
  if (ACC_W < W + 10) begin : g_chk
    $error("pmon_avg_acc: ACC_W too small");
  end

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [ACC_W-1:0] sampleExt;
  logic [ACC_W-1:0] accShift;

  //----------------------------------------------------------------------------
  // accumulate
  //----------------------------------------------------------------------------
  always_comb begin
    sampleExt = {{(ACC_W-W){SGN & sample[W-1]}}, sample};
    acc_nxt   = acc_r;
    if (clr) begin
      acc_nxt = add ? sampleExt : '0;
    end else if (add) begin
      acc_nxt = acc_r + sampleExt;
    end
    if (SGN) begin
      accShift = ACC_W'($signed(acc_r) >>> shift);
    end else begin
      accShift = acc_r >> shift;
    end
    avg = accShift[W-1:0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

endmodule

// File: pmon_conv_regs.sv
// register bank and conversion sequencer of the power monitor
`timescale 1ns/1ps
`include "pmon_regs.svh"
module pmon_conv_regs #(
  parameter int unsigned TMR_W      = 20,
  parameter int unsigned CT0_CYC    = `PM_US2CYC(`PM_CT0_US),
  parameter int unsigned CT1_CYC    = `PM_US2CYC(`PM_CT1_US),
  parameter int unsigned CT2_CYC    = `PM_US2CYC(`PM_CT2_US),
  parameter int unsigned CT3_CYC    = `PM_US2CYC(`PM_CT3_US),
  parameter int unsigned CT4_CYC    = `PM_US2CYC(`PM_CT4_US),
  parameter int unsigned CT5_CYC    = `PM_US2CYC(`PM_CT5_US),
  parameter int unsigned CT6_CYC    = `PM_US2CYC(`PM_CT6_US),
  parameter int unsigned CT7_CYC    = `PM_US2CYC(`PM_CT7_US),
  // identity values are arbitrary
  parameter logic [15:0] MAKER_CODE = 16'hA5C3,
  parameter logic [15:0] PART_CODE  = 16'h3C5A
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [15:0] regWrData,
  input  wire logic        regRdEn,
  output logic      [15:0] regRdData_r,
  output logic             regRdValid_r,
  input  wire logic [15:0] shuntSample,
  input  wire logic [14:0] railSample,
  output logic             adcShuntSel_r,
  output logic             adcRailSel_r,
  output logic             convDone_r
);

  //----------------------------------------------------------------------------
  // elaboration checks
  //----------------------------------------------------------------------------
  localparam int unsigned TMR_MAX = (1 << TMR_W) - 1;
  localparam logic [15:0] CFG_DFLT = `PM_CFG_RESET;

  if (TMR_W > 31 || CT0_CYC < 1 || CT1_CYC < 1 || CT2_CYC < 1 || CT3_CYC < 1 ||
      CT4_CYC < 1 || CT5_CYC < 1 || CT6_CYC < 1 || CT7_CYC < 1) begin : g_chk_min
    $error("pmon_conv_regs: bad timer width or zero conversion time");
  end
  if (CT0_CYC > TMR_MAX || CT1_CYC > TMR_MAX || CT2_CYC > TMR_MAX ||
      CT3_CYC > TMR_MAX || CT4_CYC > TMR_MAX || CT5_CYC > TMR_MAX ||
      CT6_CYC > TMR_MAX || CT7_CYC > TMR_MAX) begin : g_chk_max
    $error("pmon_conv_regs: conversion time exceeds timer width");
  end

  //----------------------------------------------------------------------------
  // lookups
  //----------------------------------------------------------------------------
  function automatic logic [TMR_W-1:0] ctLoad(input logic [2:0] sel);
    int unsigned cyc;
    cyc = CT0_CYC;
    unique case (sel)
      3'h0: cyc = CT0_CYC;
      3'h1: cyc = CT1_CYC;
      3'h2: cyc = CT2_CYC;
      3'h3: cyc = CT3_CYC;
      3'h4: cyc = CT4_CYC;
      3'h5: cyc = CT5_CYC;
      3'h6: cyc = CT6_CYC;
      3'h7: cyc = CT7_CYC;
    endcase
    // timer counts down to zero, so load one less
    return TMR_W'(cyc - 1);
  endfunction

  function automatic logic [9:0] avgLast(input logic [2:0] sel);
    int unsigned n;
    n = `PM_AVG_N0;
    unique case (sel)
      3'h0: n = `PM_AVG_N0;
      3'h1: n = `PM_AVG_N1;
      3'h2: n = `PM_AVG_N2;
      3'h3: n = `PM_AVG_N3;
      3'h4: n = `PM_AVG_N4;
      3'h5: n = `PM_AVG_N5;
      3'h6: n = `PM_AVG_N6;
      3'h7: n = `PM_AVG_N7;
    endcase
    return 10'(n - 1);
  endfunction

  function automatic logic [3:0] avgShift(input logic [2:0] sel);
    logic [3:0] s;
    s = 4'h0;
    unique case (sel)
      3'h0: s = 4'($clog2(`PM_AVG_N0));
      3'h1: s = 4'($clog2(`PM_AVG_N1));
      3'h2: s = 4'($clog2(`PM_AVG_N2));
      3'h3: s = 4'($clog2(`PM_AVG_N3));
      3'h4: s = 4'($clog2(`PM_AVG_N4));
      3'h5: s = 4'($clog2(`PM_AVG_N5));
      3'h6: s = 4'($clog2(`PM_AVG_N6));
      3'h7: s = 4'($clog2(`PM_AVG_N7));
    endcase
    return s;
  endfunction

  //----------------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------------
  logic [11:0]          cfg_r,       cfg_nxt;
  logic [14:0]          cal_r,       cal_nxt;
  logic [15:0]          asel_r,      asel_nxt;
  logic [15:0]          lim_r,       lim_nxt;
  logic [15:0]          regRdData_nxt;
  logic                 regRdValid_nxt;
  logic                 cfgWr;
  logic                 softRst;

  pmon_pkg::pmon_state_t state_r,    state_nxt;
  logic [TMR_W-1:0]     tmr_r,       tmr_nxt;
  logic [9:0]           smpCnt_r,    smpCnt_nxt;
  logic                 trigPend_r,  trigPend_nxt;
  logic [15:0]          shunt_r,     shunt_nxt;
  logic [14:0]          rail_r,      rail_nxt;
  logic [15:0]          curr_r,      curr_nxt;
  logic [15:0]          pwr_r,       pwr_nxt;
  logic                 adcShuntSel_nxt;
  logic                 adcRailSel_nxt;
  logic                 accClr;
  logic                 shuntAdd;
  logic                 railAdd;
  logic                 sampleEnd;
  logic                 calcDone;

  logic [2:0]           avgSel;
  logic [2:0]           railCt;
  logic [2:0]           shuntCt;
  logic                 shuntEn;
  logic                 railEn;
  logic                 contMode;
  logic [15:0]          shuntAvg;
  logic [14:0]          railAvg;
  logic [15:0]          shuntNew;
  logic [14:0]          railNew;
  logic signed [31:0]   currProd;
  logic signed [31:0]   currShift;
  logic [15:0]          currNew;
  logic [15:0]          currAbs;
  logic [30:0]          pwrProd;
  logic [30:0]          pwrShift;
  logic [15:0]          pwrNew;
  logic                 calcOvf;

  assign avgSel   = cfg_r[`PM_CFG_AVG_HI:`PM_CFG_AVG_LO];
  assign railCt   = cfg_r[`PM_CFG_RCT_HI:`PM_CFG_RCT_LO];
  assign shuntCt  = cfg_r[`PM_CFG_SCT_HI:`PM_CFG_SCT_LO];
  assign shuntEn  = cfg_r[`PM_MODE_SHUNT];
  assign railEn   = cfg_r[`PM_MODE_RAIL];
  assign contMode = cfg_r[`PM_MODE_CONT];

  //----------------------------------------------------------------------------
  // averagers
  //----------------------------------------------------------------------------
  pmon_avg_acc #(.W(16), .SGN(1'b1), .ACC_W(26)) u_shuntAcc (
    .clk    (clk),
    .rst    (rst),
    .clr    (accClr),
    .add    (shuntAdd),
    .sample (shuntSample),
    .shift  (avgShift(avgSel)),
    .avg    (shuntAvg)
  );

  pmon_avg_acc #(.W(15), .SGN(1'b0), .ACC_W(25)) u_railAcc (
    .clk    (clk),
    .rst    (rst),
    .clr    (accClr),
    .add    (railAdd),
    .sample (railSample),
    .shift  (avgShift(avgSel)),
    .avg    (railAvg)
  );

  //----------------------------------------------------------------------------
  // result arithmetic
  //----------------------------------------------------------------------------
  always_comb begin
    shuntNew  = shuntEn ? shuntAvg : shunt_r;
    railNew   = railEn ? railAvg : rail_r;
    currProd  = $signed(shuntNew) * $signed({1'b0, cal_r});
    currShift = currProd >>> `PM_CURR_SHIFT;
    currNew   = currShift[15:0];
    // magnitude only, so power never goes negative
    currAbs   = currNew[15] ? 16'(~currNew + 16'h0001) : currNew;
    pwrProd   = currAbs * railNew;
    pwrShift  = pwrProd >> `PM_PWR_SHIFT;
    pwrNew    = pwrShift[15:0];
    calcOvf   = (currShift[31:15] != {17{currShift[31]}}) || (pwrShift[30:16] != 15'h0000);
  end

  //----------------------------------------------------------------------------
  // conversion sequencer
  //----------------------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    tmr_nxt      = tmr_r;
    smpCnt_nxt   = smpCnt_r;
    trigPend_nxt = trigPend_r;
    shunt_nxt    = shunt_r;
    rail_nxt     = rail_r;
    curr_nxt     = curr_r;
    pwr_nxt      = pwr_r;
    accClr       = 1'b0;
    shuntAdd     = 1'b0;
    railAdd      = 1'b0;
    sampleEnd    = 1'b0;
    calcDone     = 1'b0;
    unique case (state_r)
      pmon_pkg::PM_IDLE: begin
        // shutdown codes leave both enables low
        // triggered set waits for a fresh write
        if ((shuntEn || railEn) && (contMode || trigPend_r)) begin
          trigPend_nxt = 1'b0;
          accClr       = 1'b1;
          smpCnt_nxt   = 10'h000;
          if (shuntEn) begin
            state_nxt = pmon_pkg::PM_SHUNT;
            tmr_nxt   = ctLoad(shuntCt);
          end else begin
            state_nxt = pmon_pkg::PM_RAIL;
            tmr_nxt   = ctLoad(railCt);
          end
        end
      end
      pmon_pkg::PM_SHUNT: begin
        if (tmr_r != '0) begin
          tmr_nxt = tmr_r - 1'b1;
        end else begin
          shuntAdd = 1'b1;
          if (railEn) begin
            state_nxt = pmon_pkg::PM_RAIL;
            tmr_nxt   = ctLoad(railCt);
          end else begin
            sampleEnd = 1'b1;
          end
        end
      end
      pmon_pkg::PM_RAIL: begin
        if (tmr_r != '0) begin
          tmr_nxt = tmr_r - 1'b1;
        end else begin
          railAdd   = 1'b1;
          sampleEnd = 1'b1;
        end
      end
      pmon_pkg::PM_CALC: begin
        // latest shunt result, 2.5 uV codes
        shunt_nxt = shuntNew;
        rail_nxt  = railNew;
        curr_nxt  = currNew;
        pwr_nxt   = pwrNew;
        calcDone  = 1'b1;
        state_nxt = pmon_pkg::PM_IDLE;
      end
    endcase
    if (sampleEnd) begin
      if (smpCnt_r == avgLast(avgSel)) begin
        state_nxt = pmon_pkg::PM_CALC;
      end else begin
        smpCnt_nxt = smpCnt_r + 10'h001;
        if (shuntEn) begin
          state_nxt = pmon_pkg::PM_SHUNT;
          tmr_nxt   = ctLoad(shuntCt);
        end else begin
          state_nxt = pmon_pkg::PM_RAIL;
          tmr_nxt   = ctLoad(railCt);
        end
      end
    end
    // write aborts and rearms with new settings
    if (cfgWr) begin
      state_nxt    = pmon_pkg::PM_IDLE;
      trigPend_nxt = 1'b1;
    end
    if (softRst) begin
      shunt_nxt = `PM_ZERO16;
      rail_nxt  = 15'h0000;
      curr_nxt  = `PM_ZERO16;
      pwr_nxt   = `PM_ZERO16;
    end
    adcShuntSel_nxt = (state_nxt == pmon_pkg::PM_SHUNT);
    adcRailSel_nxt  = (state_nxt == pmon_pkg::PM_RAIL);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r       <= pmon_pkg::PM_IDLE;
      tmr_r         <= '0;
      smpCnt_r      <= 10'h000;
      trigPend_r    <= 1'b0;
      shunt_r       <= `PM_ZERO16;
      rail_r        <= 15'h0000;
      curr_r        <= `PM_ZERO16;
      pwr_r         <= `PM_ZERO16;
      adcShuntSel_r <= 1'b0;
      adcRailSel_r  <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      tmr_r         <= tmr_nxt;
      smpCnt_r      <= smpCnt_nxt;
      trigPend_r    <= trigPend_nxt;
      shunt_r       <= shunt_nxt;
      rail_r        <= rail_nxt;
      curr_r        <= curr_nxt;
      pwr_r         <= pwr_nxt;
      adcShuntSel_r <= adcShuntSel_nxt;
      adcRailSel_r  <= adcRailSel_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // register bank
  //----------------------------------------------------------------------------
  assign cfgWr   = regWrEn && (regAddr == `PM_ADDR_CFG);
  // reset bit is never stored, so it reads back zero
  assign softRst = cfgWr && regWrData[`PM_CFG_RST_BIT];

  always_comb begin
    cfg_nxt        = cfg_r;
    cal_nxt        = cal_r;
    asel_nxt       = asel_r;
    lim_nxt        = lim_r;
    regRdValid_nxt = regRdEn;
    regRdData_nxt  = `PM_ZERO16;
    if (regRdEn) begin
      unique case (regAddr)
        // fixed upper bits read as default
        `PM_ADDR_CFG:   regRdData_nxt = {1'b0,
                                         CFG_DFLT[`PM_CFG_FIX_HI:`PM_CFG_FIX_LO], cfg_r};
        `PM_ADDR_SHUNT: regRdData_nxt = shunt_r;
        `PM_ADDR_RAIL:  regRdData_nxt = {1'b0, rail_r};
        `PM_ADDR_PWR:   regRdData_nxt = pwr_r;
        `PM_ADDR_CURR:  regRdData_nxt = curr_r;
        `PM_ADDR_CAL:   regRdData_nxt = {1'b0, cal_r};
        `PM_ADDR_ASEL:  regRdData_nxt = asel_r;
        `PM_ADDR_LIM:   regRdData_nxt = lim_r;
        `PM_ADDR_MAKER: regRdData_nxt = MAKER_CODE;
        `PM_ADDR_PART:  regRdData_nxt = PART_CODE;
        // unmapped codes read zero
        default:        regRdData_nxt = `PM_ZERO16;
      endcase
    end
    if (regWrEn) begin
      unique case (regAddr)
        `PM_ADDR_CFG:  cfg_nxt = regWrData[11:0];
        `PM_ADDR_CAL:  cal_nxt = regWrData[14:0];
        `PM_ADDR_ASEL: asel_nxt = (regWrData & `PM_ASEL_WMASK) | (asel_r & ~`PM_ASEL_WMASK);
        `PM_ADDR_LIM:  lim_nxt = regWrData;
        // result and identity codes ignore writes
        default:       cfg_nxt = cfg_r;
      endcase
    end
    // clear on read or non-power-down write
    if ((regRdEn && (regAddr == `PM_ADDR_ASEL)) ||
        (cfgWr && (regWrData[`PM_MODE_RAIL:`PM_MODE_SHUNT] != 2'b00)) || softRst) begin
      asel_nxt[`PM_ASEL_CONV_DONE_FLAG] = 1'b0;
    end
    if (softRst) begin
      cfg_nxt  = CFG_DFLT[11:0];
      cal_nxt  = 15'h0000;
      asel_nxt = `PM_ZERO16;
      lim_nxt  = `PM_ZERO16;
    end
    if (calcDone) begin
      asel_nxt[`PM_ASEL_CONV_DONE_FLAG] = 1'b1;
      asel_nxt[`PM_ASEL_OVF]  = calcOvf;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r        <= CFG_DFLT[11:0];
      cal_r        <= 15'h0000;
      asel_r       <= `PM_ZERO16;
      lim_r        <= `PM_ZERO16;
      regRdData_r  <= `PM_ZERO16;
      regRdValid_r <= 1'b0;
      convDone_r   <= 1'b0;
    end else begin
      cfg_r        <= cfg_nxt;
      cal_r        <= cal_nxt;
      asel_r       <= asel_nxt;
      lim_r        <= lim_nxt;
      regRdData_r  <= regRdData_nxt;
      regRdValid_r <= regRdValid_nxt;
      convDone_r   <= asel_nxt[`PM_ASEL_CONV_DONE_FLAG];
    end
  end

endmodule

// File: pmon_adc_model.sv
// converter stand-in that feeds the shunt and rail sample inputs
`timescale 1ns/1ps
module pmon_adc_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        shuntSel,
  input  wire logic        railSel,
  input  wire logic [15:0] shuntLevel,
  input  wire logic [14:0] railLevel,
  output logic      [15:0] shuntSample,
  output logic      [14:0] railSample
);
  logic [15:0] noise_r;
  logic [2:0]  selCnt_r;
  always_ff @(posedge clk) begin
    noise_r  <= rst ? 16'h5A5A : ~noise_r + 16'h0137;
    selCnt_r <= rst ? 3'h0 : selCnt_r + {2'b00, shuntSel};
  end
  // every other four-cycle conversion reads two counts high, even with select held
  // limitation: the alternation needs a shunt conversion time of four cycles
  assign shuntSample = shuntSel ? shuntLevel + {14'h0000, selCnt_r[2], 1'b0} : noise_r;
  // outside a conversion the code is meaningless, so it keeps moving
  assign railSample  = railSel ? railLevel : ~noise_r[14:0];
endmodule

// File: pmon_conv_regs_assertions.sv
// concurrent checks on the register port and converter selects
`timescale 1ns/1ps
module pmon_conv_regs_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic        regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic        regRdEn,
  input wire logic [15:0] regRdData_r,
  input wire logic        regRdValid_r,
  input wire logic [15:0] shuntSample,
  input wire logic [14:0] railSample,
  input wire logic        adcShuntSel_r,
  input wire logic        adcRailSel_r,
  input wire logic        convDone_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_idle; !adcShuntSel_r && !adcRailSel_r; endsequence
  sequence s_cfgWr; regWrEn && regAddr == 8'h00; endsequence
  sequence s_busyRd; regRdEn && regAddr == 8'h06 && (adcShuntSel_r || adcRailSel_r); endsequence
  property p_rdAns; regRdEn |=> regRdValid_r; endproperty
  a_rdAns: assert property (p_rdAns) else $error("read not answered");
  property p_noAns; !regRdEn |=> !regRdValid_r; endproperty
  a_noAns: assert property (p_noAns) else $error("stray read answer");
  property p_rdQuiet; !regRdValid_r |-> regRdData_r == 16'h0000; endproperty
  a_rdQuiet: assert property (p_rdQuiet) else $error("read data outside answer");
  property p_cfgFix; regRdEn && regAddr == 8'h00 |=> regRdData_r[15:12] == 4'h4; endproperty
  a_cfgFix: assert property (p_cfgFix) else $error("config top bits wrong");
  property p_railPos; regRdEn && regAddr == 8'h02 |=> !regRdData_r[15]; endproperty
  a_railPos: assert property (p_railPos) else $error("rail bit 15 set");
  property p_oneSel; !(adcShuntSel_r && adcRailSel_r); endproperty
  a_oneSel: assert property (p_oneSel) else $error("both converters selected");
  property p_wrHalt; s_cfgWr |=> s_idle; endproperty
  a_wrHalt: assert property (p_wrHalt) else $error("conversion not halted");
  property p_offStay;
    s_cfgWr and regWrData[1:0] == 2'b00 && !regWrData[15] |=> s_idle [*2];
  endproperty
  a_offStay: assert property (p_offStay) else $error("conversion in shutdown");
  property p_doneRd;
    s_busyRd ##1 (adcShuntSel_r || adcRailSel_r) |=> !convDone_r;
  endproperty
  a_doneRd: assert property (p_doneRd) else $error("done flag not cleared");
  property p_doneRise; $rose(convDone_r) |-> $past(!adcShuntSel_r && !adcRailSel_r); endproperty
  a_doneRise: assert property (p_doneRise) else $error("done during conversion");
endmodule
bind pmon_conv_regs pmon_conv_regs_assertions i_chk (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
  .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r), .shuntSample(shuntSample),
  .railSample(railSample), .adcShuntSel_r(adcShuntSel_r), .adcRailSel_r(adcRailSel_r),
  .convDone_r(convDone_r));

// File: tb.sv
// self-checking bench of the power monitor register bank
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic        regWrEn = 1'b0;
  logic [15:0] regWrData = 16'h0000;
  logic        regRdEn = 1'b0;
  logic [15:0] regRdData_r, shuntSample, d;
  logic [15:0] shuntLevel = 16'h0000;
  logic [14:0] railSample;
  logic [14:0] railLevel = 15'h0000;
  logic        regRdValid_r, adcShuntSel_r, adcRailSel_r, convDone_r;
  logic [31:0] seed = 32'hB77BC31E;
  logic [15:0] expS = 16'h0000;
  logic [15:0] expR = 16'h0000;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [7:0]  adr [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                            8'hFE, 8'hFF, 8'h08};
  logic [15:0] dflt [11] = '{16'h4127, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                             16'h0000, 16'h0000, 16'hA5C3, 16'h3C5A, 16'h0000};
  // short conversion times keep the run small
  pmon_conv_regs #(.CT0_CYC(4), .CT1_CYC(5), .CT2_CYC(6), .CT3_CYC(7), .CT4_CYC(300))
  i_pmon_conv_regs (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
    .regRdValid_r(regRdValid_r), .shuntSample(shuntSample), .railSample(railSample),
    .adcShuntSel_r(adcShuntSel_r), .adcRailSel_r(adcRailSel_r), .convDone_r(convDone_r));
  pmon_adc_model i_pmon_adc_model (.clk(clk), .rst(rst), .shuntSel(adcShuntSel_r),
    .railSel(adcRailSel_r), .shuntLevel(shuntLevel), .railLevel(railLevel),
    .shuntSample(shuntSample), .railSample(railSample));
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  // config keeps bits 11:0, bits 14:12 fixed
  function automatic logic [15:0] cfgExp(input logic [15:0] v);
    return {4'h4, v[11:0]};
  endfunction
  // four samples alternate level and level plus two
  function automatic logic [15:0] avgExp(input logic [15:0] v);
    return v + 16'h0001;
  endfunction
  // unity current scale: power is magnitude of shunt times rail, over 2^14
  function automatic logic [15:0] pwrExp(input logic [15:0] s, input logic [15:0] r);
    logic [15:0] mag;
    logic [31:0] prod;
    mag = s[15] ? -s : s;
    prod = mag * r;
    return prod[29:14];
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    `CHK(regRdValid_r, 1'b1)
    `CHK(regRdData_r, e)
  endtask
  // bounded wait; a run-out is a failure
  task automatic waitDone();
    // let the write edge settle, or a stale done flag ends the wait
    #1;
    for (int i = 0; i < 400 && convDone_r !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (convDone_r !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) rd(adr[i], dflt[i]);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'h7FFC : rnd() & 16'h7FFC;
      wr(8'h00, d);
      rd(8'h00, cfgExp(d));
      d = rnd();
      wr(8'h05, d);
      rd(8'h05, {1'b0, d[14:0]});
      wr(8'h07, ~d);
      rd(8'h07, ~d);
      wr(8'h01, d);
      rd(8'h01, 16'h0000);
      wr(8'h02, d);
      rd(8'h02, 16'h0000);
    end
    wr(8'h05, 16'h0800);
    for (int m = 1; m < 4; m++) begin
      shuntLevel <= (m == 1) ? 16'h8000 : rnd() & 16'hBFFF;
      railLevel <= (m == 2) ? 15'h7FFF : 15'(rnd());
      wr(8'h00, (m == 2) ? 16'h02C2 : 16'h0200 | m);
      waitDone();
      if (m != 2) expS = avgExp(shuntLevel);
      if (m != 1) expR = {1'b0, railLevel};
      rd(8'h01, expS);
      rd(8'h02, expR);
      rd(8'h03, pwrExp(expS, expR));
      repeat (20) @(posedge clk);
      #1;
      `CHK(adcShuntSel_r | adcRailSel_r, 1'b0)
    end
    rd(8'h03, pwrExp(expS, expR));
    rd(8'h06, 16'h0008);
    rd(8'h06, 16'h0000);
    wr(8'h00, 16'h0207);
    rd(8'h00, 16'h4207);
    `CHK(adcShuntSel_r | adcRailSel_r, 1'b1)
    shuntLevel <= rnd() & 16'hBFFF;
    railLevel <= 15'(rnd());
    wr(8'h00, 16'h0207);
    waitDone();
    rd(8'h01, avgExp(shuntLevel));
    rd(8'h02, {1'b0, railLevel});
    expS = avgExp(shuntLevel);
    wr(8'h00, 16'h0204);
    repeat (30) @(posedge clk);
    #1;
    `CHK(convDone_r, 1'b1)
    `CHK(adcShuntSel_r | adcRailSel_r, 1'b0)
    rd(8'h01, expS);
    wr(8'h00, 16'h8000);
    rd(8'h00, 16'h4127);
    rd(8'h01, 16'h0000);
    stop_test();
  end
endmodule
